// [hdl/pin_irq_cfg_pkg.sv]
// Constants and types for the input pin function and interrupt output block
package pin_irq_cfg_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] ADDR_BIDIR_MON = 8'h2a;
    localparam logic [7:0] ADDR_FUNC_SEL = 8'h2b;
    localparam logic [7:0] ADDR_INPUT_MON = 8'h2f;
    localparam logic [7:0] ADDR_IRQ_CFG = 8'h32;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h33;
    localparam logic [7:0] ADDR_IRQ_LATCH = 8'h36;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] RST_FUNC_SEL = 8'h00;
    localparam logic [7:0] RST_IRQ_CFG = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'hff;
    localparam logic [7:0] RST_IRQ_LATCH = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int BIDIR_LEVEL_BIT = 7;
    localparam int FIRST_FUNC_LSB = 4;
    localparam int SECOND_FUNC_LSB = 0;
    localparam int FIRST_LEVEL_BIT = 7;
    localparam int SECOND_LEVEL_BIT = 6;
    localparam int IRQ_POL_BIT = 7;
    localparam int IRQ_MODE_LSB = 5;
    localparam int LATCH_FILTER_BIT = 2;
    localparam int SRC_LSB = 3;
    localparam int SRC_COUNT = 5;
    // Writable bits; the rest read as zero
    localparam logic [7:0] FUNC_SEL_WMASK = 8'h77;
    localparam logic [7:0] IRQ_CFG_WMASK = 8'he4;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam longint CLK_HZ = 200_000_000;
    localparam longint IRQ_PULSE_MS = 2;
    localparam longint IRQ_PERIOD_MS = 4;
    localparam longint IRQ_PULSE_CYCLES = IRQ_PULSE_MS * CLK_HZ / 1000;
    localparam longint IRQ_PERIOD_CYCLES = IRQ_PERIOD_MS * CLK_HZ / 1000;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        FN_DISABLED = 3'b000,
        FN_GPIN = 3'b001,
        FN_MCLK = 3'b010,
        FN_SERIAL_AUDIO_DATA_INPUT = 3'b011,
        FN_PDM_DATA_PAIR_A = 3'b100,
        FN_PDM_DATA_PAIR_B = 3'b101,
        FN_RESERVED = 3'b110,
        FN_POWER_DOWN = 3'b111
    } pin_func_t;

    typedef enum logic [1:0] {
        IRQ_LEVEL = 2'b00,
        IRQ_RSVD = 2'b01,
        IRQ_REPEAT = 2'b10,
        IRQ_ONESHOT = 2'b11
    } irq_mode_t;

    // Raw levels of the monitored pins
    typedef struct packed {
        logic bidir_pin_level;
        logic first_input_level;
        logic second_input_level;
    } pin_levels_t;

    // Selected pin functions handed to the clocking and audio paths
    typedef struct packed {
        pin_func_t first_input_function;
        pin_func_t second_input_function;
        logic adc_power_down;
    } pin_funcs_t;

endpackage

// [hdl/input_pin_irq_cfg.sv]
// Input pin function select, pin level monitors and interrupt output shaping
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - 0x2a bit 7 shows bidir input level
// - Bits 6-4 select first input function
// - Bits 2-0 select mic-bias input function
// - 0x2f bit 7 shows first input level
// - 0x2f bit 6 shows mic-bias input level
// - Config bit 7 sets irq polarity
// - Mode 0 holds irq while events pending
// - Mode 2 pulses 2 ms per 4 ms
// - Mode 3 one 2 ms pulse per event
// - Config bit 2 hides masked latch bits
// - Host read clears the latched bits it returns
// - Masks reset to one, zero unmasks
module input_pin_irq_cfg #(
    parameter longint PULSE_CYCLES = pin_irq_cfg_pkg::IRQ_PULSE_CYCLES,
    parameter longint PERIOD_CYCLES = pin_irq_cfg_pkg::IRQ_PERIOD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire pin_irq_cfg_pkg::pin_levels_t pin_levels,
    input wire logic bidir_is_input,
    input wire logic [pin_irq_cfg_pkg::SRC_COUNT-1:0] irq_event,
    output var pin_irq_cfg_pkg::pin_funcs_t pin_funcs,
    output logic irq_pin
);
    import pin_irq_cfg_pkg::*;

    localparam int CW = $clog2(PERIOD_CYCLES + 1);
    localparam logic [CW-1:0] PULSE_N = CW'(PULSE_CYCLES);
    localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD_CYCLES - 1);

    // ********************************************************
    // Elaboration checks
    // ********************************************************
    generate
        if (PULSE_CYCLES < 1 || PERIOD_CYCLES <= PULSE_CYCLES) begin : g_bad_timing
            $error("Pulse must be at least one cycle and shorter than period");
        end
    endgenerate

    function automatic logic is_gpin(input logic [2:0] f);
        return f == FN_GPIN;
    endfunction

    logic [7:0] func_sel_r;
    logic [7:0] irq_cfg_r;
    logic [7:0] irq_mask_r;
    logic [7:0] irq_latch_r;
    logic [7:0] irq_latch_nxt;
    pin_levels_t sync1_r;
    pin_levels_t sync2_r;
    logic [CW-1:0] period_cnt_r;
    logic [CW-1:0] shot_cnt_r;
    logic irq_on_nxt;
    logic irq_on_r;
    logic [7:0] latch_view;
    logic [7:0] src_bits;
    logic [7:0] unmasked_src;
    logic pending;
    logic new_evt;
    logic latch_read;
    irq_mode_t mode;

    wire logic wr_cfg = reg_wr && !reg_rd;
    assign mode = irq_mode_t'(irq_cfg_r[IRQ_MODE_LSB +: 2]);
    assign src_bits = {irq_event, 3'h0};
    assign latch_read = reg_rd && reg_addr == ADDR_IRQ_LATCH;

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    // Two stages; the first is read only by the second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_levels;
            sync2_r <= sync1_r;
        end
    end

    // ********************************************************
    // Configuration registers
    // ********************************************************
    // Reserved bits are kept at zero whatever the host writes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            func_sel_r <= RST_FUNC_SEL;
            irq_cfg_r <= RST_IRQ_CFG;
            irq_mask_r <= RST_IRQ_MASK;
        end else if (wr_cfg) begin
            if (reg_addr == ADDR_FUNC_SEL) begin
                func_sel_r <= reg_wdata & FUNC_SEL_WMASK;
            end
            if (reg_addr == ADDR_IRQ_CFG) begin
                irq_cfg_r <= reg_wdata & IRQ_CFG_WMASK;
            end
            if (reg_addr == ADDR_IRQ_MASK) begin
                irq_mask_r <= reg_wdata;
            end
        end
    end

    // Decoded functions for the clocking and audio paths
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_funcs <= '{FN_DISABLED, FN_DISABLED, 1'b0};
        end else begin
            pin_funcs.first_input_function <= pin_func_t'(func_sel_r[FIRST_FUNC_LSB +: 3]);
            pin_funcs.second_input_function <= pin_func_t'(func_sel_r[SECOND_FUNC_LSB +: 3]);
            pin_funcs.adc_power_down <= func_sel_r[FIRST_FUNC_LSB +: 3] == FN_POWER_DOWN
                || func_sel_r[SECOND_FUNC_LSB +: 3] == FN_POWER_DOWN;
        end
    end

    // ********************************************************
    // Latched interrupt status
    // ********************************************************
    // Filtered view hides masked sources when asked to
    assign latch_view = irq_cfg_r[LATCH_FILTER_BIT] ? (irq_latch_r & ~irq_mask_r) : irq_latch_r;
    assign unmasked_src = src_bits & ~irq_mask_r;
    assign pending = |(irq_latch_r & ~irq_mask_r);
    assign new_evt = |unmasked_src;

    // Only the bits the host saw are cleared; a new event wins over the clear
    always_comb begin
        irq_latch_nxt = irq_latch_r;
        if (latch_read) begin
            irq_latch_nxt = irq_latch_nxt & ~latch_view;
        end
        irq_latch_nxt = irq_latch_nxt | src_bits;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_latch_r <= RST_IRQ_LATCH;
        end else begin
            irq_latch_r <= irq_latch_nxt;
        end
    end

    // ********************************************************
    // Interrupt timing
    // ********************************************************
    // Repeat period runs only while something is pending
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            period_cnt_r <= '0;
        end else if (!pending || mode != IRQ_REPEAT) begin
            period_cnt_r <= '0;
        end else if (period_cnt_r == PERIOD_LAST) begin
            period_cnt_r <= '0;
        end else begin
            period_cnt_r <= period_cnt_r + 1'b1;
        end
    end

    // A fresh event restarts the single pulse rather than extending it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shot_cnt_r <= '0;
        end else if (mode != IRQ_ONESHOT) begin
            shot_cnt_r <= '0;
        end else if (new_evt) begin
            shot_cnt_r <= PULSE_N;
        end else if (shot_cnt_r != '0) begin
            shot_cnt_r <= shot_cnt_r - 1'b1;
        end
    end

    // Reserved mode behaves as level mode so the line never sticks
    always_comb begin
        unique case (mode)
            IRQ_LEVEL: irq_on_nxt = pending;
            IRQ_RSVD: irq_on_nxt = pending;
            IRQ_REPEAT: irq_on_nxt = pending && period_cnt_r < PULSE_N;
            IRQ_ONESHOT: irq_on_nxt = new_evt || shot_cnt_r > CW'(1);
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_on_r <= 1'b0;
            irq_pin <= 1'b1;
        end else begin
            irq_on_r <= irq_on_nxt;
            irq_pin <= irq_cfg_r[IRQ_POL_BIT] ? irq_on_nxt : !irq_on_nxt;
        end
    end

    // ********************************************************
    // Register read port
    // ********************************************************
    // Monitors show zero unless the pin is a general input
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= RD_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata <= RD_UNMAPPED;
            unique case (reg_addr)
                ADDR_BIDIR_MON: reg_rdata[BIDIR_LEVEL_BIT] <= bidir_is_input && sync2_r.bidir_pin_level;
                ADDR_FUNC_SEL: reg_rdata <= func_sel_r;
                ADDR_INPUT_MON: begin
                    reg_rdata[FIRST_LEVEL_BIT] <= is_gpin(func_sel_r[FIRST_FUNC_LSB +: 3])
                        && sync2_r.first_input_level;
                    reg_rdata[SECOND_LEVEL_BIT] <= is_gpin(func_sel_r[SECOND_FUNC_LSB +: 3])
                        && sync2_r.second_input_level;
                end
                ADDR_IRQ_CFG: reg_rdata <= irq_cfg_r;
                ADDR_IRQ_MASK: reg_rdata <= irq_mask_r;
                ADDR_IRQ_LATCH: reg_rdata <= latch_view;
                default: reg_rdata <= RD_UNMAPPED;
            endcase
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    a_bidir_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == ADDR_BIDIR_MON |=> reg_rdata[6:0] == 7'h00)
        else $error("bidir monitor reserved bits not zero");

    a_first_mon_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == ADDR_INPUT_MON && func_sel_r[6:4] != FN_GPIN
        |=> reg_rdata[FIRST_LEVEL_BIT] == 1'b0 && reg_rdata[5:0] == 6'h00)
        else $error("first input level shown while not a general input");

    a_second_mon_level: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == ADDR_INPUT_MON && func_sel_r[2:0] == FN_GPIN
        |=> reg_rdata[SECOND_LEVEL_BIT] == $past(sync2_r.second_input_level))
        else $error("second input level misreported");

    a_sync_two_deep: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(rstn, 2) |-> sync2_r == $past(pin_levels, 2))
        else $error("pin synchroniser not two stages");

    a_func_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_cfg && reg_addr == ADDR_FUNC_SEL |=> ##1 pin_funcs.first_input_function == $past(reg_wdata[6:4], 2))
        else $error("first input function not taken from write");

    a_polarity_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        !irq_on_nxt && $stable(irq_cfg_r) |=> irq_pin == !$past(irq_cfg_r[IRQ_POL_BIT]))
        else $error("idle interrupt level wrong for polarity");

    a_level_mode: assert property (@(posedge core_clk) disable iff (!rstn)
        mode == IRQ_LEVEL && pending |=> irq_on_r)
        else $error("level mode dropped irq while pending");

    a_repeat_low: assert property (@(posedge core_clk) disable iff (!rstn)
        mode == IRQ_REPEAT && period_cnt_r >= PULSE_N |=> !irq_on_r)
        else $error("repeat mode high in low half of period");

    a_one_shot: assert property (@(posedge core_clk) disable iff (!rstn)
        mode == IRQ_ONESHOT && new_evt |=> irq_on_r && shot_cnt_r == PULSE_N)
        else $error("one shot pulse not started");

    a_filter_view: assert property (@(posedge core_clk) disable iff (!rstn)
        latch_read && irq_cfg_r[LATCH_FILTER_BIT] |=> (reg_rdata & $past(irq_mask_r)) == 8'h00)
        else $error("masked source visible in filtered readback");

    a_read_clears: assert property (@(posedge core_clk) disable iff (!rstn)
        latch_read && irq_event == '0 && !irq_cfg_r[LATCH_FILTER_BIT] |=> irq_latch_r == 8'h00)
        else $error("latched status not cleared by read");

    a_masked_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        mode == IRQ_LEVEL && (irq_latch_r & ~irq_mask_r) == 8'h00 |=> !irq_on_r)
        else $error("masked source reached interrupt output");

    a_second_func_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_cfg && reg_addr == ADDR_FUNC_SEL |=> ##1 pin_funcs.second_input_function == $past(reg_wdata[2:0], 2))
        else $error("second input function not taken from write");

    a_bidir_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == ADDR_BIDIR_MON && !bidir_is_input |=> !reg_rdata[BIDIR_LEVEL_BIT])
        else $error("bidir level shown while pin is not an input");

    a_first_mon_level: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == ADDR_INPUT_MON && func_sel_r[6:4] == FN_GPIN
        |=> reg_rdata[FIRST_LEVEL_BIT] == $past(sync2_r.first_input_level))
        else $error("first input level misreported");

    a_latch_set_wins: assert property (@(posedge core_clk) disable iff (!rstn)
        irq_event != '0 |=> (irq_latch_r[SRC_LSB +: SRC_COUNT] & $past(irq_event)) == $past(irq_event))
        else $error("interrupt event lost from latched status");

    a_repeat_high: assert property (@(posedge core_clk) disable iff (!rstn)
        mode == IRQ_REPEAT && pending && period_cnt_r < PULSE_N |=> irq_on_r)
        else $error("repeat mode low in high half of period");

    a_shot_ends: assert property (@(posedge core_clk) disable iff (!rstn)
        mode == IRQ_ONESHOT && !new_evt && shot_cnt_r <= CW'(1) |=> !irq_on_r)
        else $error("one shot pulse outlived its length");

endmodule

`default_nettype wire

// [tb/host_model.sv]
// Host processor model driving the parallel register port
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    import pin_irq_cfg_pkg::*;
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One write; keep clears reserved bits, all ones when a refusal is meant or the register has no reserved bits
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] keep);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d & keep;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // Released lines flip so stale values cannot pass for held ones
        reg_addr <= ~a;
        reg_wdata <= ~(d & keep);
    endtask
    // One read; data is registered, taken just after the strobe's edge
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 q = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the pin function and interrupt output block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    import pin_irq_cfg_pkg::*;
    // Short counts keep the run brief; expectations follow them
    localparam longint PULSE = 4;
    localparam longint PERIOD = 10;
    logic core_clk = 1'b0;
    logic rstn;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_rd;
    logic [7:0] reg_rdata;
    pin_levels_t pins;
    logic bidir_in;
    logic [SRC_COUNT-1:0] ev;
    pin_funcs_t funcs;
    logic irq;
    logic [7:0] q;
    logic [7:0] w;
    logic [1:0] mode;
    logic pol;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int act;
    host_model i_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    input_pin_irq_cfg #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) i_input_pin_irq_cfg (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_levels(pins),
        .bidir_is_input(bidir_in), .irq_event(ev), .pin_funcs(funcs), .irq_pin(irq));
    always #2.5 core_clk = ~core_clk;
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        i_host_model.rd(a, q);
        `CHK(q, e)
    endtask
    // One-cycle event pulse; returns just after the edge that sampled it
    task automatic pulse(input logic [SRC_COUNT-1:0] v);
        @(posedge core_clk);
        ev <= v;
        @(posedge core_clk);
        ev <= '0;
    endtask
    function automatic pin_funcs_t exp_funcs(input logic [7:0] v);
        return {v[6:4], v[2:0], (v[6:4] == 3'h7) || (v[2:0] == 3'h7)};
    endfunction
    // Active cycles over two periods from the event's edge; level mode lags the latch by one edge
    function automatic int exp_act(input logic [1:0] m);
        return int'((m == 2'h0) ? 2 * PERIOD - 1 : (m == 2'h2) ? 2 * PULSE : PULSE);
    endfunction
    initial begin
        rstn = 1'b0;
        ev = '0;
        pins = '0;
        bidir_in = 1'b0;
        void'($urandom(66766));
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1 `CHK(irq, 1'b1)
        chk_rd(ADDR_FUNC_SEL, RST_FUNC_SEL);
        chk_rd(ADDR_IRQ_CFG, RST_IRQ_CFG);
        chk_rd(ADDR_IRQ_MASK, RST_IRQ_MASK);
        chk_rd(8'h10, RD_UNMAPPED);
        // Masked events latch but leave the output idle
        pulse(5'h1f);
        repeat (3) @(posedge core_clk);
        `CHK(irq, 1'b1)
        chk_rd(ADDR_IRQ_LATCH, 8'hf8);
        chk_rd(ADDR_IRQ_LATCH, 8'h00);
        // Every code on both fields, reserved bits written as ones
        for (int c = 0; c < 8; c++) begin
            w = {1'b1, 3'(c), 1'b1, 3'(7 - c)};
            i_host_model.wr(ADDR_FUNC_SEL, w, 8'hff);
            chk_rd(ADDR_FUNC_SEL, w & 8'h77);
            `CHK(funcs, exp_funcs(w))
        end
        // Random levels and selections, read after the synchroniser settles
        for (int k = 0; k < 24; k++) begin
            w = {1'b0, 3'($urandom_range(0, 2)), 1'b0, 3'($urandom_range(0, 2))};
            i_host_model.wr(ADDR_FUNC_SEL, w, 8'h77);
            @(posedge core_clk);
            pins <= pin_levels_t'(3'($urandom_range(0, 7)));
            bidir_in <= 1'($urandom_range(0, 1));
            repeat (2) @(posedge core_clk);
            chk_rd(ADDR_INPUT_MON, {pins.first_input_level & (w[6:4] == 3'h1),
                pins.second_input_level & (w[2:0] == 3'h1), 6'h00});
            chk_rd(ADDR_BIDIR_MON, {pins.bidir_pin_level & bidir_in, 7'h00});
        end
        // Readback filter hides masked sources; read clears only what it shows
        i_host_model.wr(ADDR_IRQ_CFG, 8'hff, 8'hff);
        chk_rd(ADDR_IRQ_CFG, 8'he4);
        i_host_model.wr(ADDR_IRQ_CFG, 8'h04, 8'he4);
        i_host_model.wr(ADDR_IRQ_MASK, 8'h87, 8'hff);
        pulse(5'h11);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        chk_rd(ADDR_IRQ_LATCH, 8'h08);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        i_host_model.wr(ADDR_IRQ_CFG, 8'h00, 8'he4);
        chk_rd(ADDR_IRQ_LATCH, 8'h80);
        chk_rd(ADDR_IRQ_LATCH, 8'h00);
        // Modes 0, 2 and 3 at both polarities: count active cycles after one event
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 3; m++) begin
                pol = p[0];
                mode = (m == 0) ? 2'h0 : 2'(m + 1);
                i_host_model.wr(ADDR_IRQ_CFG, {pol, mode, 5'h00}, 8'he4);
                repeat (2) @(posedge core_clk);
                `CHK(irq, !pol)
                pulse(5'h02);
                act = 0;
                repeat (2 * PERIOD) begin
                    #1 act += int'(irq === pol);
                    @(posedge core_clk);
                end
                `CHK(act, exp_act(mode))
                chk_rd(ADDR_IRQ_LATCH, 8'h10);
                repeat (2) @(posedge core_clk);
                `CHK(irq, !pol)
            end
        end
        finish_test();
    end
endmodule
`default_nettype wire
